// *** src/panel_supply_sequencer.sv ***
// Purpose: Sequencing, soft-start and fault latch of a panel supply.
// Assumes: Comparator inputs are asynchronous and pass two flip-flops.
// Notes: Supply lockout acts as the synchronous restart of all state.
// How it works
// - Enable boost and both gate regulators together.
// - Current limit rises in eight equal steps.
// - Boost current-limit ramp ends on regulation or timeout.
// - Gate references come from 7-bit DAC codes.
// - Positive DAC ramps up over 128 steps.
// - Negative DAC ramps down over 128 steps.
// - One soft-start length for all regulators.
// - Charge delay cap when supply ok, done, unfaulted.
// - Switch block enabled at delay threshold.
// - Lockout discharges delay cap, charge off.
// - Switch select ignored until four conditions met.
// - Select high: high switch on, low off.
// - Select low: high switch off, low on.
// - Fault timer runs while any output low.
// - Continuous fault for period sets latch.
// - Latch holds until supply cycled below lockout.
// - No fault timer during soft-start; over-temperature still latches.
// - Over-temperature latches fault immediately.
// - Lockout disables regulators, switches, amplifiers.
`timescale 1ns/1ps
`default_nettype none
module panel_supply_sequencer #(
    parameter int unsigned SOFT_START_CYC = panel_supply_pkg::SOFT_START_CYC,
    parameter int unsigned FAULT_CYC = panel_supply_pkg::FAULT_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ref_good,
    input wire logic supply_ok,
    input wire logic boost_in_reg,
    input wire logic boost_low,
    input wire logic gate_pos_low,
    input wire logic gate_neg_low,
    input wire logic over_temp,
    input wire logic delay_cap_voltage,
    input wire logic switch_select_in,
    output logic boost_en,
    output logic gate_pos_en,
    output logic gate_neg_en,
    output logic [3:0] peak_current_limit,
    output logic [6:0] gate_pos_dac,
    output logic [6:0] gate_neg_dac,
    output logic soft_start_busy,
    output logic delay_capacitor_charge,
    output logic delay_cap_node_discharge,
    output logic switch_block_en,
    output logic high_side_switch,
    output logic low_side_switch,
    output logic amp_out_en,
    output logic fault_latched
);
    // ****************************************************************
    // Types and state
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_SOFT = 2'b01,
        ST_RUN = 2'b11,
        ST_FAULT = 2'b10
    } phase_t;

    // Step lengths: each ramp step is an equal share of the interval.
    localparam int unsigned DAC_STEP_CYC =
        (SOFT_START_CYC / panel_supply_pkg::DAC_STEPS > 0) ?
        SOFT_START_CYC / panel_supply_pkg::DAC_STEPS : 1;
    localparam int unsigned LIMIT_STEP_CYC =
        (SOFT_START_CYC / panel_supply_pkg::LIMIT_STEPS > 0) ?
        SOFT_START_CYC / panel_supply_pkg::LIMIT_STEPS : 1;

    typedef struct packed {
        logic [5:0] sync1;
        logic [5:0] sync2;
        logic sel1;
        logic sel2;
        phase_t phase;
        logic [31:0] ss_cnt;
        logic [31:0] dac_cnt;
        logic [31:0] limit_cnt;
        logic [31:0] flt_cnt;
        logic boost_done;
        logic [3:0] limit;
        logic [6:0] pdac;
        logic [6:0] ndac;
        logic lin_done;
        logic fault;
        logic charge;
        logic discharge;
        logic sw_en;
        logic hs;
        logic ls;
        logic regs_en;
        logic amp_en;
        logic busy;
    } state_t;

    state_t cur;
    state_t next_cur;

    // Synchronised comparator levels, read only from the second stage.
    logic s_ref, s_sup, s_inreg, s_anylow, s_otemp, s_del;
    assign s_ref = cur.sync2[0];
    assign s_sup = cur.sync2[1];
    assign s_inreg = cur.sync2[2];
    assign s_anylow = cur.sync2[3];
    assign s_otemp = cur.sync2[4];
    assign s_del = cur.sync2[5];

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // One process computes every next value from the current copy.
    always_comb begin
        next_cur = cur;
        next_cur.sync1 = {delay_cap_voltage, over_temp,
                          boost_low | gate_pos_low | gate_neg_low,
                          boost_in_reg, supply_ok, ref_good};
        next_cur.sync2 = cur.sync1;
        next_cur.sel1 = switch_select_in;
        next_cur.sel2 = cur.sel1;
        if (!s_sup) begin
            // Lockout restarts everything and clears the fault latch.
            next_cur = '0;
            next_cur.sync1 = {delay_cap_voltage, over_temp,
                              boost_low | gate_pos_low | gate_neg_low,
                              boost_in_reg, supply_ok, ref_good};
            next_cur.sync2 = cur.sync1;
            next_cur.sel1 = switch_select_in;
            next_cur.sel2 = cur.sel1;
            next_cur.discharge = 1'b1;
        end else begin
            case (cur.phase)
                ST_OFF: begin
                    next_cur.discharge = 1'b1;
                    if (s_ref) begin
                        // All three regulators start in one cycle.
                        next_cur.phase = ST_SOFT;
                        next_cur.regs_en = 1'b1;
                        next_cur.amp_en = 1'b1;
                        next_cur.pdac = panel_supply_pkg::DAC_ZERO;
                        next_cur.ndac = panel_supply_pkg::DAC_FULL;
                        next_cur.limit = panel_supply_pkg::LIMIT_ZERO;
                        next_cur.ss_cnt = '0;
                        next_cur.dac_cnt = '0;
                        next_cur.limit_cnt = '0;
                    end
                end
                ST_SOFT: begin
                    // Interval counter for the boost soft-start timeout; ramps use their own.
                    next_cur.ss_cnt = cur.ss_cnt + 32'h1;
                    if (!cur.boost_done) begin
                        if (s_inreg ||
                            cur.ss_cnt >= SOFT_START_CYC - 1) begin
                            next_cur.boost_done = 1'b1;
                            next_cur.limit = panel_supply_pkg::LIMIT_FULL;
                        end else if (cur.limit_cnt == LIMIT_STEP_CYC - 1) begin
                            next_cur.limit_cnt = '0;
                            if (cur.limit != panel_supply_pkg::LIMIT_FULL) begin
                                next_cur.limit = cur.limit + 4'h1;
                            end
                        end else begin
                            next_cur.limit_cnt = cur.limit_cnt + 32'h1;
                        end
                    end
                    if (!cur.lin_done) begin
                        if (cur.dac_cnt == DAC_STEP_CYC - 1) begin
                            next_cur.dac_cnt = '0;
                            // Codes walk the 7-bit range in 128 steps.
                            if (cur.pdac == panel_supply_pkg::DAC_FULL) begin
                                next_cur.lin_done = 1'b1;
                            end else begin
                                next_cur.pdac = cur.pdac + 7'h01;
                                next_cur.ndac = cur.ndac - 7'h01;
                            end
                        end else begin
                            next_cur.dac_cnt = cur.dac_cnt + 32'h1;
                        end
                    end
                    if (cur.boost_done && cur.lin_done) begin
                        next_cur.phase = ST_RUN;
                        next_cur.flt_cnt = '0;
                    end
                    // Fault timer stays idle during soft-start.
                    next_cur.flt_cnt = '0;
                    if (s_otemp) begin
                        next_cur.phase = ST_FAULT;
                        next_cur.fault = 1'b1;
                    end
                end
                ST_RUN: begin
                    next_cur.discharge = 1'b0;
                    next_cur.charge = 1'b1;
                    if (s_del) begin
                        next_cur.sw_en = 1'b1;
                    end
                    if (cur.sw_en) begin
                        next_cur.hs = cur.sel2;
                        next_cur.ls = ~cur.sel2;
                    end
                    // Any break in the fault restarts the period.
                    if (s_anylow) begin
                        next_cur.flt_cnt = cur.flt_cnt + 32'h1;
                    end else begin
                        next_cur.flt_cnt = '0;
                    end
                    if ((s_anylow && cur.flt_cnt >= FAULT_CYC - 1) ||
                        s_otemp) begin
                        next_cur.phase = ST_FAULT;
                        next_cur.fault = 1'b1;
                    end
                end
                ST_FAULT: begin
                    // Latched until the supply drops out.
                    next_cur.fault = 1'b1;
                end
                default: begin
                    next_cur.phase = ST_OFF;
                end
            endcase
            if (next_cur.phase == ST_FAULT) begin
                // Everything but the DAC codes goes off.
                next_cur.regs_en = 1'b0;
                next_cur.amp_en = 1'b0;
                next_cur.charge = 1'b0;
                next_cur.discharge = 1'b1;
                next_cur.sw_en = 1'b0;
                next_cur.hs = 1'b0;
                next_cur.ls = 1'b0;
                next_cur.limit = panel_supply_pkg::LIMIT_ZERO;
            end
        end
        // Busy is registered so that the output leaves a flip-flop.
        next_cur.busy = next_cur.phase == ST_SOFT;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Reset loads constants only; lockout restart is synchronous.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '0;
            cur.discharge <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs come straight from state flip-flops.
    assign boost_en = cur.regs_en;
    assign gate_pos_en = cur.regs_en;
    assign gate_neg_en = cur.regs_en;
    assign peak_current_limit = cur.limit;
    assign gate_pos_dac = cur.pdac;
    assign gate_neg_dac = cur.ndac;
    assign soft_start_busy = cur.busy;
    assign delay_capacitor_charge = cur.charge;
    assign delay_cap_node_discharge = cur.discharge;
    assign switch_block_en = cur.sw_en;
    assign high_side_switch = cur.hs;
    assign low_side_switch = cur.ls;
    assign amp_out_en = cur.amp_en;
    assign fault_latched = cur.fault;

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_ENABLE_TOGETHER: assert property (@(posedge mclk)
        disable iff (!reset_n)
        (cur.phase == ST_OFF && s_sup && s_ref) |=>
        (boost_en && gate_pos_en && gate_neg_en))
        else $error("regulators not enabled together");
    AST_LIMIT_STEP: assert property (@(posedge mclk)
        disable iff (!reset_n)
        (cur.phase == ST_SOFT && $changed(peak_current_limit) &&
         peak_current_limit != 4'h0 && !cur.boost_done) |->
        peak_current_limit == $past(peak_current_limit) + 4'h1)
        else $error("current limit step is not one eighth");
    AST_SS_END: assert property (@(posedge mclk)
        disable iff (!reset_n)
        (cur.phase == ST_SOFT && s_sup && !s_otemp && s_inreg) |=>
        cur.boost_done)
        else $error("soft-start did not end on regulation");
    AST_DAC_MIRROR: assert property (@(posedge mclk)
        disable iff (!reset_n)
        cur.phase == ST_SOFT |-> gate_pos_dac + gate_neg_dac == 7'h7f)
        else $error("negative ramp does not mirror positive ramp");
    AST_DISCHARGE: assert property (@(posedge mclk)
        disable iff (!reset_n)
        !s_sup |=> delay_cap_node_discharge && !delay_capacitor_charge)
        else $error("delay cap not discharged in lockout");
    AST_SWITCH_GATE: assert property (@(posedge mclk)
        disable iff (!reset_n)
        (high_side_switch || low_side_switch) |-> switch_block_en &&
        !fault_latched)
        else $error("switch driven while inactive");
    AST_SWITCH_EXCL: assert property (@(posedge mclk)
        disable iff (!reset_n)
        !(high_side_switch && low_side_switch))
        else $error("both switches closed");
    AST_OTEMP: assert property (@(posedge mclk)
        disable iff (!reset_n)
        (s_sup && s_otemp && cur.phase != ST_OFF) |=>
        fault_latched && !boost_en)
        else $error("over-temperature did not latch at once");
    AST_LATCH_HOLD: assert property (@(posedge mclk)
        disable iff (!reset_n)
        (fault_latched && s_sup) |=> fault_latched)
        else $error("fault latch cleared without lockout");
    AST_NO_FAULT_SS: assert property (@(posedge mclk)
        disable iff (!reset_n)
        cur.phase == ST_SOFT |-> cur.flt_cnt == 32'h0)
        else $error("fault timer ran during soft-start");
endmodule : panel_supply_sequencer
`default_nettype wire

// *** src/panel_supply_pkg.sv ***
// Purpose: Shared constants for the panel supply sequencer.
// Assumes: 20 MHz system clock.
// Notes: Times are kept in their own units; cycle counts derive from them.
package panel_supply_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    // Soft-start length in microseconds, common to all three regulators.
    localparam int unsigned SOFT_START_US = 14_000;
    localparam int unsigned SOFT_START_CYC =
        SOFT_START_US * (CLK_HZ / 1_000_000);
    // Fault timer period in microseconds.
    localparam int unsigned FAULT_TIME_US = 200_000;
    localparam int unsigned FAULT_CYC = FAULT_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned DAC_W = 7;
    localparam int unsigned DAC_STEPS = 128;
    localparam int unsigned LIMIT_W = 4;
    localparam int unsigned LIMIT_STEPS = 8;
    localparam logic [6:0] DAC_ZERO = 7'h00;
    localparam logic [6:0] DAC_FULL = 7'h7f;
    localparam logic [3:0] LIMIT_ZERO = 4'h0;
    localparam logic [3:0] LIMIT_FULL = 4'h8;
    localparam int unsigned CNT_W = 32;
endpackage : panel_supply_pkg

// *** test/panel_analog_model.sv ***
// Purpose: Analog rails, comparators and delay capacitor around the block.
// Assumes: One clock; rails settle a fixed time after their enable.
// Notes: A rail reads below threshold while off or still rising.
`timescale 1ns/1ps
`default_nettype none
module panel_analog_model #(
    parameter int RISE = 100,
    parameter int CAP_TRIP = 20
) (
    input wire logic mclk,
    input wire logic boost_en,
    input wire logic gate_pos_en,
    input wire logic gate_neg_en,
    input wire logic charge,
    input wire logic discharge,
    input wire logic fast_reg,
    input wire logic [2:0] sag,
    output logic boost_in_reg,
    output logic boost_low,
    output logic gate_pos_low,
    output logic gate_neg_low,
    output logic delay_cap_voltage
);
    int up = 0;
    int cap = 0;
    // Rail age and capacitor charge; discharge wins over charge.
    always @(posedge mclk) begin
        up <= boost_en ? up + 1 : 0;
        if (discharge)
            cap <= 0;
        else if (charge)
            cap <= cap + 1;
    end
    // A slow rail never reports regulation, so the timer must end it.
    assign boost_in_reg = boost_en && up > (fast_reg ? 40 : 100000);
    assign boost_low = !boost_en || up < RISE || sag[0];
    assign gate_pos_low = !gate_pos_en || up < RISE || sag[1];
    assign gate_neg_low = !gate_neg_en || up < RISE || sag[2];
    assign delay_cap_voltage = cap >= CAP_TRIP;
endmodule : panel_analog_model
`default_nettype wire

// *** test/panel_supply_sequencer_bench.sv ***
// Purpose: Self-checking bench of the panel supply sequencer.
// Assumes: Short counts: soft-start 256 cycles, fault timer 64.
// Notes: Inputs move 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
    total_checks++; \
    if ((a) !== (b)) begin \
        err_count++; \
        $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); \
    end \
end
module panel_supply_sequencer_bench;
    logic mclk = 0, reset_n = 0, ref_good = 0, supply_ok = 0;
    logic over_temp = 0, switch_select_in = 0, fast_reg = 0;
    logic [2:0] sag = 3'h0;
    logic boost_in_reg, boost_low, gate_pos_low, gate_neg_low, dcv;
    logic boost_en, gate_pos_en, gate_neg_en, soft_start_busy;
    logic [3:0] peak_current_limit;
    logic [6:0] gate_pos_dac, gate_neg_dac;
    logic delay_capacitor_charge, delay_cap_node_discharge;
    logic switch_block_en, high_side_switch, low_side_switch;
    logic amp_out_en, fault_latched;
    int err_count = 0, total_checks = 0, cyc = 0;
    // ****
    // Design and analog side
    // ****
    panel_supply_sequencer #(.SOFT_START_CYC(256), .FAULT_CYC(64)) uut (
        .mclk(mclk), .reset_n(reset_n), .ref_good(ref_good),
        .supply_ok(supply_ok), .boost_in_reg(boost_in_reg),
        .boost_low(boost_low), .gate_pos_low(gate_pos_low),
        .gate_neg_low(gate_neg_low), .over_temp(over_temp),
        .delay_cap_voltage(dcv), .switch_select_in(switch_select_in),
        .boost_en(boost_en), .gate_pos_en(gate_pos_en),
        .gate_neg_en(gate_neg_en), .peak_current_limit(peak_current_limit),
        .gate_pos_dac(gate_pos_dac), .gate_neg_dac(gate_neg_dac),
        .soft_start_busy(soft_start_busy),
        .delay_capacitor_charge(delay_capacitor_charge),
        .delay_cap_node_discharge(delay_cap_node_discharge),
        .switch_block_en(switch_block_en),
        .high_side_switch(high_side_switch),
        .low_side_switch(low_side_switch), .amp_out_en(amp_out_en),
        .fault_latched(fault_latched));
    panel_analog_model ana (
        .mclk(mclk), .boost_en(boost_en), .gate_pos_en(gate_pos_en),
        .gate_neg_en(gate_neg_en), .charge(delay_capacitor_charge),
        .discharge(delay_cap_node_discharge), .fast_reg(fast_reg),
        .sag(sag), .boost_in_reg(boost_in_reg), .boost_low(boost_low),
        .gate_pos_low(gate_pos_low), .gate_neg_low(gate_neg_low),
        .delay_cap_voltage(dcv));
    // Clock, and a cycle ceiling so a hang still ends in the report.
    initial begin
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    // Full start: ramps watched each cycle, rails sagging early on.
    task automatic t_startup();
        int n, bad;
        logic [6:0] pd, nd;
        logic [3:0] pl;
        `CHK(delay_cap_node_discharge, 1'b1);
        `CHK(delay_capacitor_charge, 1'b0);
        sag = 3'h7;
        supply_ok = 1'b1;
        ref_good = 1'b1;
        n = 0;
        bad = 0;
        while (boost_en !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        `CHK({gate_pos_en, gate_neg_en}, 2'h3);
        `CHK(gate_pos_dac, 7'h00);
        `CHK(gate_neg_dac, 7'h7f);
        `CHK(peak_current_limit, 4'h0);
        n = 0;
        while (soft_start_busy !== 1'b0 && n < 400) begin
            pd = gate_pos_dac;
            nd = gate_neg_dac;
            pl = peak_current_limit;
            tick(1);
            n++;
            if (n == 200)
                sag = 3'h0;
            if (7'(gate_pos_dac - pd) > 7'h1)
                bad++;
            if (7'(nd - gate_neg_dac) > 7'h1)
                bad++;
            if (4'(peak_current_limit - pl) > 4'h1)
                bad++;
            if (delay_capacitor_charge !== 1'b0)
                bad++;
            if (fault_latched !== 1'b0)
                bad++;
        end
        `CHK(bad, 0);
        `CHK(n >= 250 && n <= 300, 1'b1);
        `CHK(gate_pos_dac, 7'h7f);
        `CHK(gate_neg_dac, 7'h00);
        `CHK(peak_current_limit, 4'h8);
        switch_select_in = 1'b1;
        tick(4);
        `CHK(delay_capacitor_charge, 1'b1);
        `CHK(delay_cap_node_discharge, 1'b0);
        `CHK({switch_block_en, high_side_switch}, 2'h0);
        n = 0;
        while (switch_block_en !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        `CHK(n > 12 && n < 40, 1'b1);
        tick(3);
        `CHK({high_side_switch, low_side_switch}, 2'h2);
        `CHK(amp_out_en, 1'b1);
        switch_select_in = 1'b0;
        tick(5);
        `CHK({high_side_switch, low_side_switch}, 2'h1);
    endtask : t_startup
    // A broken sag must not latch; an unbroken one must, and stay.
    task automatic t_fault();
        int n;
        sag = 3'h4;
        tick(50);
        sag = 3'h0;
        tick(3);
        sag = 3'h4;
        tick(50);
        `CHK(fault_latched, 1'b0);
        n = 0;
        while (fault_latched !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        `CHK(n >= 8 && n <= 24, 1'b1);
        `CHK({boost_en, gate_pos_en, gate_neg_en}, 3'h0);
        `CHK({switch_block_en, amp_out_en}, 2'h0);
        `CHK({high_side_switch, low_side_switch}, 2'h0);
        sag = 3'h0;
        tick(20);
        `CHK(fault_latched, 1'b1);
        supply_ok = 1'b0;
        tick(5);
        `CHK(fault_latched, 1'b0);
        `CHK({gate_pos_dac, peak_current_limit}, 11'h000);
        `CHK(amp_out_en, 1'b0);
        `CHK(delay_cap_node_discharge, 1'b1);
    endtask : t_fault
    // Heat latches at once, with no timer.
    task automatic t_overtemp();
        int n;
        over_temp = 1'b1;
        tick(2);
        over_temp = 1'b0;
        n = 0;
        while (fault_latched !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        `CHK(n <= 4, 1'b1);
        tick(10);
        `CHK({fault_latched, boost_en, switch_block_en}, 3'h4);
    endtask : t_overtemp
    // Regulation reached early ends the current-limit ramp at once.
    task automatic t_boost_early();
        supply_ok = 1'b0;
        fast_reg = 1'b1;
        tick(4);
        supply_ok = 1'b1;
        tick(70);
        `CHK(peak_current_limit, 4'h8);
        `CHK(soft_start_busy, 1'b1);
    endtask : t_boost_early
    initial begin
        tick(8);
        reset_n = 1'b1;
        tick(2);
        t_startup();
        t_fault();
        t_startup();
        t_overtemp();
        t_boost_early();
        summarize();
    end
endmodule : panel_supply_sequencer_bench
`default_nettype wire
